/* File: design/flash_cmd_pkg.sv */
// Constants shared by the serial flash command interpreter and its host controller.
package flash_cmd_pkg;

    // ------------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------------
    localparam logic [7:0] OP_ID_A            = 8'h90;
    localparam logic [7:0] OP_ID_B            = 8'hAB;
    localparam logic [7:0] OP_ARM_STATUS      = 8'h50;
    localparam logic [7:0] OP_STATUS_WRITE    = 8'h01;

    // ------------------------------------------------------------------
    // Frame and field layout
    // ------------------------------------------------------------------
    localparam int         BYTE_BITS          = 8;
    localparam int         ADDR_BITS          = 24;
    localparam int         CNT_W              = 6;
    localparam logic [5:0] OPCODE_DONE        = 6'h08;
    localparam logic [5:0] ADDR_DONE          = 6'h18;
    localparam logic [5:0] DATA_DONE          = 6'h10;
    localparam int         LVL_LO_POS         = 2;
    localparam int         LVL_HI_POS         = 3;
    localparam int         LOCK_POS           = 7;
    localparam logic [2:0] PROTECT_RESET      = 3'h0;

    // ------------------------------------------------------------------
    // Host register map, one aligned word each
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_CTRL           = 8'h00;
    localparam logic [7:0] REG_WDATA          = 8'h04;
    localparam logic [7:0] REG_STATUS         = 8'h08;
    localparam logic [7:0] REG_RDATA          = 8'h0C;
    localparam logic [7:0] REG_DIV            = 8'h10;
    localparam int         CTRL_GO_POS        = 0;
    localparam int         CTRL_HOLD_POS      = 1;
    localparam logic [15:0] DIV_RESET         = 16'h0002;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int         CLK_MHZ            = 40;
    localparam int         POWER_UP_US        = 10;
    localparam int         POWER_UP_CYCLES    = POWER_UP_US * CLK_MHZ;

endpackage

/* File: design/flash_link_if.sv */
// Serial link between the host controller and the flash command interpreter.
`timescale 1ns/1ps
interface flash_link_if;
    logic sclk;
    logic sel_n;
    logic mosi;
    logic miso;
    logic miso_oe_n;

    modport host
    (
        output sclk,
        output sel_n,
        output mosi,
        input  miso
    );

    modport device
    (
        input  sclk,
        input  sel_n,
        input  mosi,
        output miso,
        output miso_oe_n
    );
endinterface

/* File: design/edge_sync.sv */
// Two-stage synchroniser with edge detection on the second stage output.
`timescale 1ns/1ps
module edge_sync
    import flash_cmd_pkg::*;
#(
    parameter logic RESET_VAL = 1'b0
)
(
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst_b,
    // Asynchronous input and results
    input  wire logic din,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic meta;
    logic prev;

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta  <= RESET_VAL;
            level <= RESET_VAL;
            prev  <= RESET_VAL;
        end
        else
        begin
            meta  <= din;
            level <= meta;
            prev  <= level;
        end
    end

    assign rise = level & ~prev;
    assign fall = ~level & prev;
endmodule

/* File: design/flash_cmd_device.sv */
// Flash command interpreter: status write arming, protect bits and identification read.
`timescale 1ns/1ps
// Contract
// - Arm instruction enables next status write
// - Arm lost unless status write follows
// - Host frames arm with select
// - Status write changes only protect bits
// - Host sends status write next
// - Ignore write when pin low, locked
// - Pin low: lock sets, never clears
// - Pin high: all protect bits writable
// - Judge permission before select rises
// - One write locks and sets levels
// - Host holds select through write
// - Identification opcodes 90H/ABH, 24 address bits
// - Address 0 maker, 1 part code
// - Codes alternate until select rises
// - Host waits 10 us after power
// - Host sends address zero except bit0
module flash_cmd_device
    import flash_cmd_pkg::*;
#(
    parameter logic [7:0] MAKER_CODE = 8'hA5,  // Arbitrary value.
    parameter logic [7:0] PART_CODE  = 8'h5A   // Arbitrary value.
)
(
    // Clock and reset
    input  wire logic     core_clk,
    input  wire logic     rst_b,
    // Serial link
    flash_link_if.device  link,
    // Protection pin, active low
    input  wire logic     wp_b,
    // Status outputs
    output logic          protect_level_hi,
    output logic          protect_level_lo,
    output logic          protect_lock,
    output logic          armed
);
    typedef enum logic [1:0] {PH_OPCODE, PH_ADDR, PH_DATA, PH_IDLE} phase_t;

    phase_t            phase;
    logic              sclk_rise;
    logic              sclk_fall;
    logic              sel_n_s;
    logic              sel_rise;
    logic              mosi_s;
    logic              wp_b_s;
    logic [CNT_W-1:0]  bit_cnt;
    logic [7:0]        shift_in;
    logic [7:0]        opcode;
    logic              id_sel;
    logic              addr_lsb;
    logic [7:0]        shift_out;
    logic [2:0]        bit_out;
    logic              data_done;
    logic [7:0]        data_byte;
    logic [7:0]        next_shift_in;
    logic              is_id;
    logic              next_id_sel;
    logic [7:0]        id_code;

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    edge_sync #(.RESET_VAL(1'b0)) u_sclk
    (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .din      (link.sclk),
        .level    (),
        .rise     (sclk_rise),
        .fall     (sclk_fall)
    );

    edge_sync #(.RESET_VAL(1'b1)) u_sel
    (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .din      (link.sel_n),
        .level    (sel_n_s),
        .rise     (sel_rise),
        .fall     ()
    );

    edge_sync #(.RESET_VAL(1'b0)) u_mosi
    (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .din      (link.mosi),
        .level    (mosi_s),
        .rise     (),
        .fall     ()
    );

    edge_sync #(.RESET_VAL(1'b1)) u_wp
    (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .din      (wp_b),
        .level    (wp_b_s),
        .rise     (),
        .fall     ()
    );

    assign next_shift_in = {shift_in[6:0], mosi_s};
    assign is_id         = (opcode == OP_ID_A) || (opcode == OP_ID_B);
    assign next_id_sel   = link.miso_oe_n ? addr_lsb : ~id_sel;
    assign id_code       = next_id_sel ? PART_CODE : MAKER_CODE;

    // ------------------------------------------------------------------
    // Input shifter and phase tracking
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            phase     <= PH_OPCODE;
            bit_cnt   <= '0;
            shift_in  <= '0;
            opcode    <= '0;
            addr_lsb  <= 1'b0;
            data_done <= 1'b0;
            data_byte <= '0;
        end
        else if (sel_n_s)
        begin
            phase     <= PH_OPCODE;
            bit_cnt   <= '0;
            data_done <= 1'b0;
        end
        else if (sclk_rise)
        begin
            shift_in <= next_shift_in;
            bit_cnt  <= bit_cnt + 1'b1;
            case (phase)
                PH_OPCODE:
                begin
                    if (bit_cnt + 1'b1 == OPCODE_DONE)
                    begin
                        opcode  <= next_shift_in;
                        bit_cnt <= '0;
                        if ((next_shift_in == OP_ID_A) || (next_shift_in == OP_ID_B))
                            phase <= PH_ADDR;
                        else if (next_shift_in == OP_STATUS_WRITE)
                            phase <= PH_DATA;
                        else
                            phase <= PH_IDLE;
                    end
                end
                PH_ADDR:
                begin
                    if (bit_cnt + 1'b1 == ADDR_DONE)
                    begin
                        addr_lsb <= mosi_s;
                        phase    <= PH_IDLE;
                    end
                end
                PH_DATA:
                begin
                    if (bit_cnt + 1'b1 == OPCODE_DONE)
                    begin
                        data_byte <= next_shift_in;
                        data_done <= 1'b1;
                        phase     <= PH_IDLE;
                    end
                end
                default:
                begin
                    bit_cnt <= bit_cnt;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Arming and protect bits, executed when select rises
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            armed <= 1'b0;
        else if (sel_rise && phase != PH_OPCODE || sel_rise && opcode == OP_ARM_STATUS)
        begin
            if (opcode == OP_ARM_STATUS && phase == PH_IDLE)
                armed <= 1'b1;
            else
                armed <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            protect_level_hi <= PROTECT_RESET[0];
            protect_level_lo <= PROTECT_RESET[1];
            protect_lock     <= PROTECT_RESET[2];
        end
        else if (sel_rise && armed && opcode == OP_STATUS_WRITE && data_done)
        begin
            // lock honoured only with pin low
            if (wp_b_s || !protect_lock)
            begin
                protect_level_hi <= data_byte[LVL_HI_POS];
                protect_level_lo <= data_byte[LVL_LO_POS];
                // lock may be set at either pin level
                protect_lock     <= data_byte[LOCK_POS] | (!wp_b_s & protect_lock);
            end
        end
    end

    // ------------------------------------------------------------------
    // Identification output
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            id_sel         <= 1'b0;
            shift_out      <= '0;
            bit_out        <= '0;
            link.miso      <= 1'b0;
            link.miso_oe_n <= 1'b1;
        end
        else if (sel_n_s)
        begin
            bit_out        <= '0;
            link.miso_oe_n <= 1'b1;
        end
        else if (sclk_fall && phase == PH_IDLE && is_id)
        begin
            link.miso_oe_n <= 1'b0;
            bit_out        <= bit_out + 1'b1;
            if (bit_out == '0)
            begin
                id_sel    <= next_id_sel;
                link.miso <= id_code[7];
                shift_out <= {id_code[6:0], 1'b0};
            end
            else
            begin
                link.miso <= shift_out[7];
                shift_out <= {shift_out[6:0], 1'b0};
            end
        end
    end
endmodule

/* File: design/flash_host_ctrl.sv */
// Host controller: APB registers drive serial frames toward the flash device.
`timescale 1ns/1ps
module flash_host_ctrl
    import flash_cmd_pkg::*;
#(
    parameter int PU_CYCLES = POWER_UP_CYCLES
)
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Serial link
    flash_link_if.host       link
);
    typedef enum logic [1:0] {S_WAIT, S_IDLE, S_SHIFT, S_END} hstate_t;

    hstate_t      state;
    logic [15:0]  div;
    logic [15:0]  div_cnt;
    logic [15:0]  pu_cnt;
    logic [5:0]   nbits;
    logic [5:0]   sent;
    logic [31:0]  tx;
    logic [31:0]  rx;
    logic         hold;
    logic         tick;
    logic         miso_m;
    logic         miso_s;
    logic         wr;
    logic         busy;

    assign wr   = psel && penable && pwrite;
    assign tick = (div_cnt == '0);
    assign busy = (state != S_IDLE);

    // ------------------------------------------------------------------
    // Register access, answered in the first access cycle
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            div     <= DIV_RESET;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable)
            begin
                if (paddr == REG_STATUS)
                    prdata <= {31'h0, busy};
                else if (paddr == REG_RDATA)
                    prdata <= rx;
                else if (paddr == REG_DIV)
                    prdata <= {16'h0, div};
                else if (paddr == REG_WDATA)
                    prdata <= tx;
                else if (paddr == REG_CTRL)
                    prdata <= {24'h0, nbits, hold, 1'b0};
                else
                begin
                    prdata  <= '0;
                    pslverr <= 1'b1;
                end
            end
            if (wr && pready && paddr == REG_DIV)
                div <= pwdata[15:0];
        end
    end

    // ------------------------------------------------------------------
    // Frame engine
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            miso_m <= 1'b0;
            miso_s <= 1'b0;
        end
        else
        begin
            miso_m <= link.miso;
            miso_s <= miso_m;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state      <= S_WAIT;
            pu_cnt     <= '0;
            div_cnt    <= '0;
            nbits      <= '0;
            sent       <= '0;
            tx         <= '0;
            rx         <= '0;
            hold       <= 1'b0;
            link.sclk  <= 1'b0;
            link.sel_n <= 1'b1;
            link.mosi  <= 1'b0;
        end
        else
        begin
            div_cnt <= tick ? div : div_cnt - 1'b1;
            if (wr && pready && paddr == REG_WDATA && !busy)
                tx <= pwdata;
            case (state)
                S_WAIT:
                begin
                    pu_cnt <= pu_cnt + 1'b1;
                    if (32'(pu_cnt) >= PU_CYCLES - 1)
                        state <= S_IDLE;
                end
                S_IDLE:
                begin
                    if (wr && pready && paddr == REG_CTRL && pwdata[CTRL_GO_POS])
                    begin
                        nbits      <= pwdata[7:2];
                        hold       <= pwdata[CTRL_HOLD_POS];
                        sent       <= '0;
                        link.sel_n <= 1'b0;
                        link.mosi  <= tx[31];
                        state      <= S_SHIFT;
                    end
                end
                S_SHIFT:
                begin
                    if (tick)
                    begin
                        link.sclk <= ~link.sclk;
                        if (!link.sclk)
                        begin
                            rx   <= {rx[30:0], miso_s};
                            sent <= sent + 1'b1;
                        end
                        else if (sent == nbits)
                            state <= S_END;
                        else
                        begin
                            tx        <= {tx[30:0], 1'b0};
                            link.mosi <= tx[30];
                        end
                    end
                end
                default:
                begin
                    if (tick)
                    begin
                        link.sel_n <= !hold;
                        state      <= S_IDLE;
                    end
                end
            endcase
        end
    end
endmodule

/* File: tb/flash_link_props.sv */
// Concurrent checks on the serial link and the protect state of the flash device.
`timescale 1ns/1ps
module flash_link_props
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Serial link
    input wire logic sclk,
    input wire logic sel_n,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe_n,
    // Protection pin and device state
    input wire logic wp_b,
    input wire logic protect_level_hi,
    input wire logic protect_level_lo,
    input wire logic protect_lock,
    input wire logic armed
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    // ------------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------------
    // The pin is held for four samples so the device's synchroniser has settled.
    sequence s_pin_low_locked;
        !wp_b [*4] ##0 protect_lock;
    endsequence

    sequence s_frame_end;
        $rose(sel_n);
    endsequence

    sequence s_protect_change;
        $changed({protect_level_hi, protect_level_lo, protect_lock});
    endsequence

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    // lock sticks
    AST_LOCK_STICKS: assert property (s_pin_low_locked |=> protect_lock)
        else $error("protect lock cleared while pin low");
    AST_LEVELS_FROZEN: assert property (
        s_pin_low_locked |=> $stable({protect_level_hi, protect_level_lo}))
        else $error("protect levels changed while locked");
    AST_WRITE_NEEDS_ARM: assert property (s_protect_change |-> $past(armed))
        else $error("protect bits changed without arming");
    AST_CHANGE_AT_FRAME_END: assert property (
        s_protect_change |-> $past(sel_n) && !$past(sel_n, 8))
        else $error("protect bits changed away from frame end");
    AST_ARM_AT_FRAME_END: assert property (
        $rose(armed) |-> $past(sel_n) && !$past(sel_n, 8))
        else $error("arming outside frame end");
    AST_DISARM_AT_FRAME_END: assert property ($fell(armed) |-> sel_n)
        else $error("arming dropped inside a frame");
    AST_OE_RELEASE: assert property (s_frame_end |-> ##[1:6] miso_oe_n)
        else $error("data output still driven after deselect");
    AST_MISO_ON_FALL: assert property (
        !miso_oe_n && $changed(miso) |-> !$past(sclk, 3) || !$past(sclk, 4))
        else $error("data output changed away from a clock fall");
    AST_SCLK_IN_FRAME: assert property (
        $changed(sclk) |-> !sel_n || !$past(sel_n))
        else $error("serial clock moved while deselected");
    AST_MOSI_STABLE: assert property ($rose(sclk) |-> $stable(mosi))
        else $error("host data changed at the sampling edge");
endmodule

/* File: tb/spi_flash_status_protect_and_id_bench.sv */
// Self-checking bench joining the host controller and the flash command interpreter.
`timescale 1ns/1ps
module spi_flash_status_protect_and_id_bench
    import flash_cmd_pkg::*;
;
    localparam logic [7:0] MAKER  = 8'hC3;  // Arbitrary value.
    localparam logic [7:0] PART   = 8'h3C;  // Arbitrary value.
    localparam logic [7:0] ID_OPS [2] = '{OP_ID_A, OP_ID_B};

    logic        core_clk;
    logic        rst_b;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        wp_b;
    logic        protect_level_hi;
    logic        protect_level_lo;
    logic        protect_lock;
    logic        armed;
    logic [3:0]  st;
    logic [31:0] q;
    logic        err;
    int          num_errors;
    int          compares;
    int          cycles;

    assign st = {armed, protect_lock, protect_level_hi, protect_level_lo};

    flash_link_if i_flash_link_if ();

    flash_host_ctrl #(.PU_CYCLES(4)) i_flash_host_ctrl (.core_clk(core_clk), .rst_b(rst_b),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(i_flash_link_if.host));

    flash_cmd_device #(.MAKER_CODE(MAKER), .PART_CODE(PART)) i_flash_cmd_device (
        .core_clk(core_clk), .rst_b(rst_b), .link(i_flash_link_if.device), .wp_b(wp_b),
        .protect_level_hi(protect_level_hi), .protect_level_lo(protect_level_lo),
        .protect_lock(protect_lock), .armed(armed));

    flash_link_props i_flash_link_props (.core_clk(core_clk), .rst_b(rst_b),
        .sclk(i_flash_link_if.sclk), .sel_n(i_flash_link_if.sel_n),
        .mosi(i_flash_link_if.mosi), .miso(i_flash_link_if.miso),
        .miso_oe_n(i_flash_link_if.miso_oe_n), .wp_b(wp_b),
        .protect_level_hi(protect_level_hi), .protect_level_lo(protect_level_lo),
        .protect_lock(protect_lock), .armed(armed));

    always #12.5 core_clk = ~core_clk;

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        if (num_errors == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Entered just after a rising edge; an idle cycle follows so calls never collide.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'h1;
        // Only the bench timeout ends a wait for the answer.
        do
        begin
            @(posedge core_clk);
        end
        while (pready !== 1'h1);
        q = prdata;
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge core_clk);
    endtask

    task automatic wait_idle();
        do
        begin
            apb(1'h0, REG_STATUS, 32'h0);
        end
        while (q[0] !== 1'h0);
    endtask

    task automatic frame(input logic [31:0] bits, input int n, input logic hold);
        apb(1'h1, REG_WDATA, bits << (32 - n));
        apb(1'h1, REG_CTRL, {24'h0, 6'(n), hold, 1'h1});
        wait_idle();
        repeat (8) @(posedge core_clk);
        chk(i_flash_link_if.sel_n, {31'h0, !hold});
        chk(i_flash_link_if.sclk, 1'h0);
    endtask

    // Bits outside the protect fields are set so a careless write would show.
    function automatic logic [31:0] sw(input logic lock, input logic hi, input logic lo);
        logic [7:0] d;
        d = 8'h73;
        d[LOCK_POS] = lock;
        d[LVL_HI_POS] = hi;
        d[LVL_LO_POS] = lo;
        return {16'h0, OP_STATUS_WRITE, d};
    endfunction

    task automatic arm_write(input logic [31:0] w, input logic [3:0] exp);
        frame({24'h0, OP_ARM_STATUS}, 8, 1'h0);
        chk(armed, 1'h1);
        frame(w, 16, 1'h0);
        chk(st, exp);
    endtask

    // ------------------------------------------------------------------
    // Timeout and main sequence
    // ------------------------------------------------------------------
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            finish_test();
        end
    end

    initial
    begin
        core_clk = 1'h0;
        rst_b = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        wp_b = 1'h1;
        num_errors = 0;
        compares = 0;
        cycles = 0;
        repeat (8) @(posedge core_clk);
        rst_b <= 1'h1;
        @(posedge core_clk);
        chk(st, 4'h0);
        // A half period of eight clocks covers the round trip through both synchronisers.
        apb(1'h1, REG_DIV, 32'h7);
        wait_idle();
        apb(1'h0, 8'h20, 32'h0);
        chk(err, 1'h1);
        frame(sw(1'h1, 1'h1, 1'h1), 16, 1'h0);
        chk(st, 4'h0);
        arm_write(sw(1'h0, 1'h1, 1'h1), 4'h3);
        frame({24'h0, OP_ARM_STATUS}, 8, 1'h0);
        frame({OP_ID_A, 24'h0}, 32, 1'h0);
        chk(st, 4'h3);
        frame(sw(1'h1, 1'h0, 1'h0), 16, 1'h0);
        chk(st, 4'h3);
        wp_b <= 1'h0;
        arm_write(sw(1'h1, 1'h0, 1'h1), 4'h5);
        arm_write(sw(1'h0, 1'h1, 1'h0), 4'h5);
        wp_b <= 1'h1;
        arm_write(sw(1'h0, 1'h1, 1'h0), 4'h2);
        arm_write(sw(1'h1, 1'h1, 1'h1), 4'h7);
        frame({24'h0, OP_ARM_STATUS}, 8, 1'h0);
        fork
            frame(sw(1'h0, 1'h0, 1'h0), 16, 1'h0);
            begin
                repeat (40) @(posedge core_clk);
                wp_b <= 1'h0;
            end
        join
        chk(st, 4'h7);
        wp_b <= 1'h1;
        arm_write(sw(1'h0, 1'h0, 1'h0), 4'h0);
        foreach (ID_OPS[i])
            for (int a = 0; a < 2; a++)
            begin
                frame({ID_OPS[i], 23'h0, 1'(a)}, 32, 1'h1);
                frame(32'h0, 24, 1'h0);
                apb(1'h0, REG_RDATA, 32'h0);
                chk(q[23:0], (a == 1) ? {PART, MAKER, PART} : {MAKER, PART, MAKER});
            end
        finish_test();
    end
endmodule
